// ===== logic/cxf_pkg.sv
`default_nettype none
package cxf_pkg;
  localparam int unsigned CXF_MAX_FILTERS = 64;
  localparam logic [6:0] CXF_MAX_SIZE = 7'h40;

  // Register byte offsets
  localparam logic [11:0] CXF_OFF_CTRL = 12'h000;
  localparam logic [11:0] CXF_OFF_INT_FLAGS = 12'h004;
  localparam logic [11:0] CXF_OFF_INT_MASK = 12'h008;
  localparam logic [11:0] CXF_OFF_PRIO_STATUS = 12'h00c;
  localparam logic [11:0] CXF_OFF_EXT_LIST_CFG = 12'h010;
  localparam logic [11:0] CXF_OFF_EXT_MASK = 12'h014;
  localparam logic [11:0] CXF_OFF_TX_PENDING = 12'h018;
  localparam logic [11:0] CXF_OFF_TX_ADD = 12'h01c;
  localparam logic [11:0] CXF_OFF_TX_CANCEL_FIN = 12'h020;
  localparam logic [11:0] CXF_OFF_TX_OCCURRED = 12'h0d8;

  // Reset values
  localparam logic [31:0] CXF_RST_ZERO = 32'h0000_0000;
  localparam logic [28:0] CXF_RST_EXT_MASK = 29'h1fff_ffff;

  // Field positions
  localparam int unsigned CXF_CTRL_NO_AUTO_RETX = 0;
  localparam int unsigned CXF_INT_HPM = 0;
  localparam int unsigned CXF_INT_TX_DONE = 1;
  localparam int unsigned CXF_INT_TX_CANCEL = 2;
  localparam int unsigned CXF_INT_W = 3;
  localparam int unsigned CXF_CFG_START_LSB = 0;
  localparam int unsigned CXF_CFG_SIZE_LSB = 16;

  // Element configuration codes (first word bits 31:29)
  localparam logic [2:0] CXF_EC_DISABLE = 3'h0;
  localparam logic [2:0] CXF_EC_FIFO0 = 3'h1;
  localparam logic [2:0] CXF_EC_FIFO1 = 3'h2;
  localparam logic [2:0] CXF_EC_REJECT = 3'h3;
  localparam logic [2:0] CXF_EC_PRIO = 3'h4;
  localparam logic [2:0] CXF_EC_PRIO_FIFO0 = 3'h5;
  localparam logic [2:0] CXF_EC_PRIO_FIFO1 = 3'h6;
  localparam logic [2:0] CXF_EC_BUFFER = 3'h7;

  // Filter types (second word bits 31:30)
  localparam logic [1:0] CXF_FT_RANGE = 2'h0;
  localparam logic [1:0] CXF_FT_DUAL = 2'h1;
  localparam logic [1:0] CXF_FT_CLASSIC = 2'h2;
  localparam logic [1:0] CXF_FT_RANGE_NOMASK = 2'h3;

  // Message storage indicator in priority status
  localparam logic [1:0] CXF_MSI_NONE = 2'h0;
  localparam logic [1:0] CXF_MSI_FIFO0 = 2'h2;
  localparam logic [1:0] CXF_MSI_FIFO1 = 2'h3;

  typedef enum logic [2:0] {
    CXF_DST_NONE = 3'b000,
    CXF_DST_FIFO0 = 3'b001,
    CXF_DST_FIFO1 = 3'b010,
    CXF_DST_RXBUF = 3'b011,
    CXF_DST_DBG_A = 3'b100,
    CXF_DST_DBG_B = 3'b101,
    CXF_DST_DBG_C = 3'b110
  } cxf_dest_t;

  typedef struct packed {
    logic [28:0] id;
    logic ext;
  } cxf_rx_frame_t;

  typedef struct packed {
    logic valid;
    logic matched;
    logic prio;
    cxf_dest_t dest;
    logic [5:0] buf_index;
    logic [5:0] filter_index;
  } cxf_result_t;
endpackage
`default_nettype wire

// ===== logic/cxf_filter_tx.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Up to 64 extended-identifier filter elements filter 29-bit frames.
// - Element word address is list start plus twice the index.
// - Enabled elements take part in filtering; disabled ones are skipped.
// - Filtering stops at first enabled match or after the last element.
// - Configs 4, 5, 6 on match set priority flag, interrupt, status.
// - Config field bits 31:29 select disable, FIFO, reject or priority.
// - Config 7 routes to receive buffer or debug slot, ignoring type.
// - First identifier; buffer targets need exact match after global mask.
// - Type 0 accepts identifiers from first to second, inclusive.
// - Second identifier bits 10:9 pick receive buffer or debug A/B/C.
// - Second identifier bits 5:0 give the receive buffer index.
// - Without auto retransmit, failed transmissions cancel and set cancel bit.
// - Pending bit reads 1 while a request is outstanding.
// - Read-only transmit-occurred register, one bit per buffer, resets zero.
// - Occurred bit sets when pending clears after successful transmission.
// - Writing one to add-request clears that buffer's occurred bit.
module cxf_filter_tx
  import cxf_pkg::*;
#(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned NUM_TX = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire cxf_rx_frame_t rx_frame,
  output logic rx_ready,
  output cxf_result_t result,
  output logic mram_req,
  output logic [ADDR_W-1:0] mram_addr,
  input wire logic mram_rvalid,
  input wire logic [31:0] mram_rdata,
  input wire logic [NUM_TX-1:0] tx_success,
  input wire logic [NUM_TX-1:0] tx_failed,
  output logic [NUM_TX-1:0] tx_pending,
  output logic irq
);

  typedef enum logic [1:0] {
    CXF_S_IDLE = 2'b00,
    CXF_S_READ0 = 2'b01,
    CXF_S_READ1 = 2'b10,
    CXF_S_EVAL = 2'b11
  } cxf_state_t;

  cxf_state_t state_q;
  cxf_rx_frame_t frame_q;
  cxf_result_t result_q;
  logic [5:0] idx_q;
  logic [31:0] word0_q;
  logic [31:0] word1_q;
  logic mram_req_q;
  logic [ADDR_W-1:0] mram_addr_q;
  logic rx_ready_q;

  logic no_auto_retransmit_q;
  logic [CXF_INT_W-1:0] int_flags_q;
  logic [CXF_INT_W-1:0] int_flags_d;
  logic [CXF_INT_W-1:0] int_mask_q;
  logic [15:0] prio_status_q;
  logic [ADDR_W-1:0] ext_list_start_address_q;
  logic [6:0] list_size_q;
  logic [28:0] ext_id_global_mask_q;
  logic [NUM_TX-1:0] pend_q;
  logic [NUM_TX-1:0] pend_d;
  logic [NUM_TX-1:0] cancel_fin_q;
  logic [NUM_TX-1:0] cancel_fin_d;
  logic [NUM_TX-1:0] occurred_q;
  logic [NUM_TX-1:0] occurred_d;
  logic irq_q;

  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // APB decode
  logic setup;
  logic wr;
  logic [NUM_TX-1:0] add_req;
  logic [NUM_TX-1:0] fail_cancel;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & pready_q & ~pslverr_q;
  assign add_req = (wr && paddr == CXF_OFF_TX_ADD) ?
                   pwdata[NUM_TX-1:0] : '0;

  always_comb begin
    rd_mux = CXF_RST_ZERO;
    rd_hit = 1'b1;
    case (paddr)
      CXF_OFF_CTRL: rd_mux[CXF_CTRL_NO_AUTO_RETX] = no_auto_retransmit_q;
      CXF_OFF_INT_FLAGS: rd_mux[CXF_INT_W-1:0] = int_flags_q;
      CXF_OFF_INT_MASK: rd_mux[CXF_INT_W-1:0] = int_mask_q;
      CXF_OFF_PRIO_STATUS: rd_mux[15:0] = prio_status_q;
      CXF_OFF_EXT_LIST_CFG: begin
        rd_mux[CXF_CFG_START_LSB +: ADDR_W] = ext_list_start_address_q;
        rd_mux[CXF_CFG_SIZE_LSB +: 7] = list_size_q;
      end
      CXF_OFF_EXT_MASK: rd_mux[28:0] = ext_id_global_mask_q;
      CXF_OFF_TX_PENDING: rd_mux[NUM_TX-1:0] = pend_q;
      CXF_OFF_TX_ADD: rd_mux = CXF_RST_ZERO;
      CXF_OFF_TX_CANCEL_FIN: rd_mux[NUM_TX-1:0] = cancel_fin_q;
      CXF_OFF_TX_OCCURRED: rd_mux[NUM_TX-1:0] = occurred_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // Answer is prepared in the setup cycle, so no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= CXF_RST_ZERO;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~rd_hit;
      if (setup) begin
        prdata_q <= pwrite ? CXF_RST_ZERO : rd_mux;
      end
    end
  end

  // Software configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      no_auto_retransmit_q <= 1'b0;
      int_mask_q <= '0;
      ext_list_start_address_q <= '0;
      list_size_q <= '0;
      ext_id_global_mask_q <= CXF_RST_EXT_MASK;
    end else if (wr) begin
      case (paddr)
        CXF_OFF_CTRL:
          no_auto_retransmit_q <= pwdata[CXF_CTRL_NO_AUTO_RETX];
        CXF_OFF_INT_MASK: int_mask_q <= pwdata[CXF_INT_W-1:0];
        CXF_OFF_EXT_LIST_CFG: begin
          ext_list_start_address_q <= pwdata[CXF_CFG_START_LSB +: ADDR_W];
          // Sizes beyond the list capacity are clamped
          list_size_q <= (pwdata[CXF_CFG_SIZE_LSB +: 7] > CXF_MAX_SIZE) ?
                         CXF_MAX_SIZE : pwdata[CXF_CFG_SIZE_LSB +: 7];
        end
        CXF_OFF_EXT_MASK: ext_id_global_mask_q <= pwdata[28:0];
        default: ;
      endcase
    end
  end

  // Element decode of the fetched words
  logic [2:0] ext_element_config;
  logic [28:0] ext_first_identifier;
  logic [1:0] ext_filter_type;
  logic [28:0] ext_second_identifier;
  logic [28:0] id_masked;
  logic [28:0] id_raw;
  logic hit;
  logic is_last;
  logic [ADDR_W-1:0] elem_addr;
  logic [5:0] idx_next;

  assign ext_element_config = word0_q[31:29];
  assign ext_first_identifier = word0_q[28:0];
  assign ext_filter_type = word1_q[31:30];
  assign ext_second_identifier = word1_q[28:0];
  assign id_raw = frame_q.id;
  assign id_masked = frame_q.id & ext_id_global_mask_q;
  assign is_last = ({1'b0, idx_q} == list_size_q - 7'd1);
  assign idx_next = idx_q + 6'd1;
  assign elem_addr = ext_list_start_address_q +
                     ADDR_W'({idx_q, 1'b0});

  always_comb begin
    hit = 1'b0;
    if (ext_element_config == CXF_EC_BUFFER) begin
      hit = (id_masked == (ext_first_identifier & ext_id_global_mask_q));
    end else begin
      case (ext_filter_type)
        CXF_FT_RANGE: hit = (id_masked >= ext_first_identifier) &&
                            (id_masked <= ext_second_identifier);
        CXF_FT_DUAL: hit = (id_masked == ext_first_identifier) ||
                           (id_masked == ext_second_identifier);
        CXF_FT_CLASSIC: hit = ((id_raw & ext_second_identifier) ==
                               (ext_first_identifier &
                                ext_second_identifier));
        CXF_FT_RANGE_NOMASK: hit = (id_raw >= ext_first_identifier) &&
                                   (id_raw <= ext_second_identifier);
        default: hit = 1'b0;
      endcase
    end
  end

  // Outcome of a matching element
  cxf_result_t match_res;
  always_comb begin
    match_res = '0;
    match_res.valid = 1'b1;
    match_res.filter_index = idx_q;
    match_res.buf_index = ext_second_identifier[5:0];
    match_res.prio = (ext_element_config == CXF_EC_PRIO) ||
                     (ext_element_config == CXF_EC_PRIO_FIFO0) ||
                     (ext_element_config == CXF_EC_PRIO_FIFO1);
    case (ext_element_config)
      CXF_EC_FIFO0, CXF_EC_PRIO_FIFO0: begin
        match_res.matched = 1'b1;
        match_res.dest = CXF_DST_FIFO0;
      end
      CXF_EC_FIFO1, CXF_EC_PRIO_FIFO1: begin
        match_res.matched = 1'b1;
        match_res.dest = CXF_DST_FIFO1;
      end
      CXF_EC_BUFFER: begin
        match_res.matched = 1'b1;
        case (ext_second_identifier[10:9])
          2'h0: match_res.dest = CXF_DST_RXBUF;
          2'h1: match_res.dest = CXF_DST_DBG_A;
          2'h2: match_res.dest = CXF_DST_DBG_B;
          default: match_res.dest = CXF_DST_DBG_C;
        endcase
      end
      default: begin
        // Reject and priority-only store nothing
        match_res.matched = 1'b1;
        match_res.dest = CXF_DST_NONE;
      end
    endcase
  end

  // Filter engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CXF_S_IDLE;
      frame_q <= '0;
      result_q <= '0;
      idx_q <= '0;
      word0_q <= CXF_RST_ZERO;
      word1_q <= CXF_RST_ZERO;
      mram_req_q <= 1'b0;
      mram_addr_q <= '0;
      rx_ready_q <= 1'b0;
    end else begin
      result_q.valid <= 1'b0;
      case (state_q)
        CXF_S_IDLE: begin
          rx_ready_q <= 1'b1;
          if (rx_valid && rx_ready_q && rx_frame.ext) begin
            frame_q <= rx_frame;
            idx_q <= '0;
            rx_ready_q <= 1'b0;
            if (list_size_q == 7'd0) begin
              result_q <= '0;
              result_q.valid <= 1'b1;
              rx_ready_q <= 1'b1;
            end else begin
              mram_req_q <= 1'b1;
              mram_addr_q <= ext_list_start_address_q;
              state_q <= CXF_S_READ0;
            end
          end
        end
        CXF_S_READ0: begin
          if (mram_rvalid) begin
            word0_q <= mram_rdata;
            if (mram_rdata[31:29] == CXF_EC_DISABLE) begin
              if (is_last) begin
                mram_req_q <= 1'b0;
                result_q <= '0;
                result_q.valid <= 1'b1;
                rx_ready_q <= 1'b1;
                state_q <= CXF_S_IDLE;
              end else begin
                idx_q <= idx_next;
                mram_addr_q <= elem_addr + ADDR_W'(2);
              end
            end else begin
              mram_addr_q <= elem_addr + ADDR_W'(1);
              state_q <= CXF_S_READ1;
            end
          end
        end
        CXF_S_READ1: begin
          if (mram_rvalid) begin
            word1_q <= mram_rdata;
            mram_req_q <= 1'b0;
            state_q <= CXF_S_EVAL;
          end
        end
        CXF_S_EVAL: begin
          if (hit) begin
            result_q <= match_res;
            rx_ready_q <= 1'b1;
            state_q <= CXF_S_IDLE;
          end else if (is_last) begin
            result_q <= '0;
            result_q.valid <= 1'b1;
            rx_ready_q <= 1'b1;
            state_q <= CXF_S_IDLE;
          end else begin
            idx_q <= idx_next;
            mram_req_q <= 1'b1;
            mram_addr_q <= elem_addr + ADDR_W'(2);
            state_q <= CXF_S_READ0;
          end
        end
        default: state_q <= CXF_S_IDLE;
      endcase
    end
  end

  // Priority match status: buffer index, storage, filter index, list
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_status_q <= '0;
    end else if (result_q.valid && result_q.prio) begin
      prio_status_q[5:0] <= result_q.buf_index;
      prio_status_q[7:6] <= (result_q.dest == CXF_DST_FIFO0) ?
                            CXF_MSI_FIFO0 :
                            (result_q.dest == CXF_DST_FIFO1) ?
                            CXF_MSI_FIFO1 : CXF_MSI_NONE;
      prio_status_q[13:8] <= result_q.filter_index;
      prio_status_q[14] <= 1'b0;
      prio_status_q[15] <= 1'b1;
    end
  end

  // Transmit buffer status; a new request wins over a same-cycle clear
  assign fail_cancel = tx_failed & pend_q &
                       {NUM_TX{no_auto_retransmit_q}};
  assign pend_d = (pend_q & ~tx_success & ~fail_cancel) | add_req;
  assign occurred_d = (occurred_q & ~add_req) |
                      (tx_success & pend_q);
  assign cancel_fin_d = (cancel_fin_q & ~add_req) | fail_cancel;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
      occurred_q <= '0;
      cancel_fin_q <= '0;
    end else begin
      pend_q <= pend_d;
      occurred_q <= occurred_d;
      cancel_fin_q <= cancel_fin_d;
    end
  end

  // Interrupt flags: write one to clear, a same-cycle event wins
  logic [CXF_INT_W-1:0] int_set;
  logic [CXF_INT_W-1:0] int_clr;

  always_comb begin
    int_set = '0;
    int_set[CXF_INT_HPM] = result_q.valid & result_q.prio;
    int_set[CXF_INT_TX_DONE] = |(tx_success & pend_q);
    int_set[CXF_INT_TX_CANCEL] = |fail_cancel;
    int_clr = (wr && paddr == CXF_OFF_INT_FLAGS) ?
              pwdata[CXF_INT_W-1:0] : '0;
    int_flags_d = (int_flags_q & ~int_clr) | int_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_flags_q <= '0;
      irq_q <= 1'b0;
    end else begin
      int_flags_q <= int_flags_d;
      irq_q <= |(int_flags_d & int_mask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rx_ready = rx_ready_q;
  assign result = result_q;
  assign mram_req = mram_req_q;
  assign mram_addr = mram_addr_q;
  assign tx_pending = pend_q;
  assign irq = irq_q;

endmodule
`default_nettype wire

// ===== tb/cxf_filter_tx_props.sv
`timescale 1ns/1ps
`default_nettype none
module cxf_filter_tx_props
  import cxf_pkg::*;
#(
  parameter int unsigned NUM_TX = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire cxf_rx_frame_t rx_frame,
  input wire logic rx_ready,
  input wire cxf_result_t result,
  input wire logic [NUM_TX-1:0] tx_success,
  input wire logic [NUM_TX-1:0] tx_failed,
  input wire logic [NUM_TX-1:0] tx_pending
);
  logic add0;
  assign add0 = psel && penable && pwrite && paddr == CXF_OFF_TX_ADD &&
    pwdata[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY_ONE: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  AST_UNMAPPED: assert property (psel && !penable && paddr == 12'h100
    |=> pslverr && prdata == 32'h0000_0000) else $error("no error");
  AST_OCC_MAPPED: assert property (
    psel && !penable && paddr == CXF_OFF_TX_OCCURRED |=> !pslverr)
    else $error("occurred register refused");
  AST_NO_MATCH: assert property (
    result.valid && !result.matched |-> result.dest == CXF_DST_NONE &&
    !result.prio) else $error("unmatched frame stored");
  AST_PRIO_DEST: assert property (
    result.valid && result.prio |-> result.matched && result.dest inside
    {CXF_DST_NONE, CXF_DST_FIFO0, CXF_DST_FIFO1}) else $error("bad prio");
  AST_TAKE_BUSY: assert property (
    rx_valid && rx_ready && rx_frame.ext |=> !rx_ready || result.valid)
    else $error("engine not busy");
  AST_DONE_READY: assert property (result.valid |-> rx_ready)
    else $error("not ready at result");
  AST_ADD_PEND: assert property (add0 && pready |=> tx_pending[0])
    else $error("pending not set");
  AST_OK_CLEAR: assert property (
    tx_pending[0] && tx_success[0] && !add0 |=> !tx_pending[0])
    else $error("pending not cleared");
  AST_IGNORE_FAIL: assert property (
    !tx_pending[0] && tx_failed[0] && !add0 |=> !tx_pending[0])
    else $error("idle buffer became pending");
  cover property (result.valid && result.prio);
  cover property (pready && pslverr);
  cover property (tx_pending[0] && tx_success[0]);
endmodule

bind cxf_filter_tx cxf_filter_tx_props #(.NUM_TX(NUM_TX)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
  .rx_frame(rx_frame), .rx_ready(rx_ready), .result(result),
  .tx_success(tx_success), .tx_failed(tx_failed),
  .tx_pending(tx_pending)
);
`default_nettype wire

// ===== tb/cxf_mram_model.sv
`timescale 1ns/1ps
`default_nettype none
module cxf_mram_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic req,
  input wire logic [15:0] addr,
  output logic rvalid,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:255];
  logic [1:0] wait_q;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 32'h0000_0000;
  end
  // Slow mode answers on the third cycle of a held request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wait_q <= 2'h0;
    else if (rvalid || !req) wait_q <= 2'h0;
    else wait_q <= wait_q + 2'h1;
  end
  assign rvalid = req && (!slow || wait_q == 2'h2);
  // Off-answer data inverted so a stale sample cannot pass
  assign rdata = rvalid ? mem[addr[7:0]] : ~mem[addr[7:0]];
endmodule
`default_nettype wire

// ===== tb/cxf_filter_tx_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cxf_filter_tx_tb_top;
  import cxf_pkg::*;
  typedef struct {
    logic [2:0] c;
    logic [1:0] t;
    logic [28:0] a, b, id;
    logic [4:0] exp;
  } cxf_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, mram_rdata, rd;
  logic pready, pslverr, rx_valid = 0, rx_ready, mram_req, mram_rvalid;
  logic irq, err;
  cxf_rx_frame_t rx_frame = '0;
  cxf_result_t result, res;
  logic [15:0] mram_addr;
  logic [31:0] tx_success = 0, tx_failed = 0, tx_pending;
  int mismatches = 0, checked = 0, cycles = 0;
  // {matched, prio, dest}; range 0x64..0xc8, exact id for buffer rows
  cxf_row_t rows [17] = '{
    '{3'h0, 2'h0, 29'h64, 29'hc8, 29'h96, 5'h00},
    '{3'h1, 2'h0, 29'h64, 29'hc8, 29'h96, 5'h11},
    '{3'h2, 2'h0, 29'h64, 29'hc8, 29'hc8, 5'h12},
    '{3'h3, 2'h0, 29'h64, 29'hc8, 29'h64, 5'h10},
    '{3'h4, 2'h0, 29'h64, 29'hc8, 29'h96, 5'h18},
    '{3'h5, 2'h0, 29'h64, 29'hc8, 29'h96, 5'h19},
    '{3'h6, 2'h0, 29'h64, 29'hc8, 29'h64, 5'h1a},
    '{3'h1, 2'h0, 29'h64, 29'hc8, 29'hc9, 5'h00},
    '{3'h1, 2'h1, 29'h64, 29'hc8, 29'hc8, 5'h11},
    '{3'h1, 2'h1, 29'h64, 29'hc8, 29'h96, 5'h00},
    '{3'h1, 2'h2, 29'h100, 29'h1fff_ff00, 29'h1ab, 5'h11},
    '{3'h2, 2'h3, 29'h64, 29'hc8, 29'h70, 5'h12},
    '{3'h7, 2'h3, 29'h123_4567, 29'h005, 29'h123_4567, 5'h13},
    '{3'h7, 2'h3, 29'h123_4567, 29'h205, 29'h123_4567, 5'h14},
    '{3'h7, 2'h3, 29'h123_4567, 29'h405, 29'h123_4567, 5'h15},
    '{3'h7, 2'h3, 29'h123_4567, 29'h605, 29'h123_4567, 5'h16},
    '{3'h7, 2'h3, 29'h123_4567, 29'h405, 29'h123_4568, 5'h00}};

  cxf_filter_tx DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready),
    .result(result), .mram_req(mram_req), .mram_addr(mram_addr),
    .mram_rvalid(mram_rvalid), .mram_rdata(mram_rdata),
    .tx_success(tx_success), .tx_failed(tx_failed),
    .tx_pending(tx_pending), .irq(irq));
  cxf_mram_model u_ram (.clk(pclk), .rst_n(presetn), .slow(slow),
    .req(mram_req), .addr(mram_addr), .rvalid(mram_rvalid),
    .rdata(mram_rdata));

  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task close_out;
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task frame(input logic [28:0] fid);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_frame <= '{id: fid, ext: 1'b1};
    do @(posedge pclk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    do @(posedge pclk); while (result.valid !== 1'b1);
    res = result;
  endtask
  task elem(input int i, input logic [2:0] c, input logic [1:0] t,
            input logic [28:0] a, input logic [28:0] b);
    u_ram.mem[16 + 2 * i] = {c, a};
    u_ram.mem[17 + 2 * i] = {t, 1'b0, b};
  endtask
  task pulse(input logic ok, input logic [31:0] m);
    @(posedge pclk);
    if (ok) tx_success <= m;
    else tx_failed <= m;
    @(posedge pclk);
    tx_success <= 32'h0000_0000;
    tx_failed <= 32'h0000_0000;
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CXF_OFF_TX_OCCURRED, 32'h0000_0000);
    chk(rd, CXF_RST_ZERO, "occurred reset");
    apb(1'b0, CXF_OFF_EXT_MASK, 32'h0000_0000);
    chk(rd, {3'h0, CXF_RST_EXT_MASK}, "mask reset");
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001, "unmapped");
    apb(1'b1, CXF_OFF_EXT_LIST_CFG, 32'h0001_0010);
    foreach (rows[i]) begin
      elem(0, rows[i].c, rows[i].t, rows[i].a, rows[i].b);
      frame(rows[i].id);
      chk({27'h0, res.matched, res.prio, res.dest},
          {27'h0, rows[i].exp}, "routing");
      if (rows[i].c == 3'h7 && rows[i].exp != 5'h00)
        chk({26'h0, res.buf_index}, 32'h0000_0005, "buffer index");
    end
    // Flags set above but masked: line must stay low
    chk({31'h0, irq}, 32'h0000_0000, "masked irq");
    slow <= 1'b1;
    apb(1'b1, CXF_OFF_INT_MASK, 32'h0000_0007);
    apb(1'b1, CXF_OFF_EXT_LIST_CFG, 32'h0002_0010);
    elem(0, CXF_EC_FIFO0, 2'h0, 29'h10, 29'h20);
    elem(1, CXF_EC_PRIO_FIFO1, 2'h0, 29'h10, 29'h20);
    frame(29'h18);
    chk({26'h0, res.filter_index}, 32'h0000_0000, "first match");
    chk({29'h0, res.dest}, {29'h0, CXF_DST_FIFO0}, "first dest");
    elem(0, CXF_EC_DISABLE, 2'h0, 29'h10, 29'h20);
    frame(29'h18);
    chk({26'h0, res.filter_index}, 32'h0000_0001, "skip");
    apb(1'b0, CXF_OFF_PRIO_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_ffc0, 32'h0000_81c0, "prio status");
    chk({31'h0, irq}, 32'h0000_0001, "irq raised");
    apb(1'b1, CXF_OFF_INT_FLAGS, 32'h0000_0007);
    apb(1'b0, CXF_OFF_INT_FLAGS, 32'h0000_0000);
    chk(rd & 32'h0000_0001, 32'h0000_0000, "flag cleared");
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    apb(1'b1, CXF_OFF_TX_ADD, 32'h0000_0003);
    pulse(1'b0, 32'h0000_0002);
    pulse(1'b1, 32'h0000_0001);
    apb(1'b0, CXF_OFF_TX_PENDING, 32'h0000_0000);
    chk(rd, 32'h0000_0002, "pending");
    apb(1'b0, CXF_OFF_TX_OCCURRED, 32'h0000_0000);
    chk(rd, 32'h0000_0001, "occurred");
    apb(1'b1, CXF_OFF_CTRL, 32'h0000_0001);
    pulse(1'b0, 32'h0000_0003);
    apb(1'b0, CXF_OFF_TX_PENDING, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "cancelled");
    apb(1'b0, CXF_OFF_TX_CANCEL_FIN, 32'h0000_0000);
    chk(rd, 32'h0000_0002, "cancel finished");
    apb(1'b1, CXF_OFF_TX_OCCURRED, 32'hffff_ffff);
    apb(1'b0, CXF_OFF_TX_OCCURRED, 32'h0000_0000);
    chk(rd, 32'h0000_0001, "read only");
    apb(1'b1, CXF_OFF_TX_ADD, 32'h0000_0001);
    apb(1'b0, CXF_OFF_TX_OCCURRED, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "occurred cleared");
    apb(1'b1, CXF_OFF_EXT_LIST_CFG, 32'h0050_0010);
    apb(1'b0, CXF_OFF_EXT_LIST_CFG, 32'h0000_0000);
    chk(rd, 32'h0040_0010, "size clamped");
    pulse(1'b1, 32'h0000_0001);
    apb(1'b0, CXF_OFF_TX_OCCURRED, 32'h0000_0000);
    chk(rd, 32'h0000_0001, "occurred again");
    // Mid-run reset must drop occurred, pending and list configuration
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CXF_OFF_TX_OCCURRED, 32'h0000_0000);
    chk(rd, CXF_RST_ZERO, "occurred after reset");
    apb(1'b0, CXF_OFF_EXT_LIST_CFG, 32'h0000_0000);
    chk(rd, CXF_RST_ZERO, "config after reset");
    apb(1'b0, CXF_OFF_TX_PENDING, 32'h0000_0000);
    chk(rd, CXF_RST_ZERO, "pending after reset");
    close_out();
  end
endmodule
`default_nettype wire
